// ---- core/ahs_small_lookup.sv ----
// Small hash table classification lookup with result selection
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Select bit0 TCAM/hash, bit1 small/large
// - Hash of chosen header fields indexes table
// - 512 entries: hash low eight, bucket bit8
// - Several bucket hits: higher entry wins
// - Hit needs valid and equal stored key
// - Bit 236 forwards to processor port
// - Original frame to processor, tunnel exit kept
// - Tag info 16 bits, valid, precedence bit
// - Bit 256 discards and bumps drop counter
// - Bit 257 redirects to four-bit port
// - Ingress copy to port, with precedence
// - Bit 268 suppresses source address learning
// - Bit 269 bumps indexed match counter
// - TOS rewrite per mask bit
// - Outer VLAN DEI, PCP, VID rewrites
// - TPID replace: 8100, 88a8, user value
// - VLAN rewrite precedence bits resolve conflicts
// - IPv4 only source/destination address rewrite
// - Transport source/destination port rewrite
// - Translation pointer, version, precedence
// - PTP flag and ingress timestamp to processor
// - Encapsulation entry, table choice, precedence
// - Key ANDed with small table mask
// - Key from first seven selected fields
module ahs_small_lookup (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ahs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire ahs_pkg::ahs_req_t req,
  input wire ahs_pkg::ahs_answer_t tcam_answer,
  input wire ahs_pkg::ahs_answer_t large_answer,
  output ahs_pkg::ahs_action_t act
);
  import ahs_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] sel;
    logic [MASK_WORDS-1:0][31:0] smask;
    logic [15:0] user_tpid;
    logic [31:0] drops;
    logic [NCNT-1:0][31:0] cnt;
    logic [ENTRIES-1:0][WORDS-1:0][31:0] tbl;
    logic [31:0] rdata;
    ahs_action_t act;
  } ahs_state_t;

  ahs_state_t st;
  ahs_state_t next_st;

  // ==========================================================
  // Helpers
  // Address falls inside a window of n words from base
  function automatic logic in_win(logic [ADDR_W-1:0] a,
                                  logic [ADDR_W-1:0] base,
                                  logic [ADDR_W-1:0] n);
    logic [ADDR_W-1:0] off;
    off = a - base;
    return (a >= base) && (off < n);
  endfunction

  // Bits of word w that lie below a field width
  function automatic logic [31:0] live_bits(int unsigned w,
                                            int unsigned width);
    logic [31:0] m;
    m = '0;
    for (int unsigned b = 0; b < 32; b++)
      m[b] = ((w * 32 + b) < width);
    return m;
  endfunction

  // Pack the first seven selected fields into the key
  function automatic ahs_key_t select_key(
      logic [NFIELDS-1:0] sel,
      logic [NFIELDS-1:0][FIELD_W-1:0] f);
    ahs_key_t k;
    int unsigned n;
    k = '0;
    n = 0;
    for (int unsigned i = 0; i < NFIELDS; i++)
    begin
      if (sel[i] && (n < KEY_FIELDS))
      begin
        k[n*FIELD_W +: FIELD_W] = f[i];
        n = n + 1;
      end
    end
    return k;
  endfunction

  // Fold the key into the row index
  function automatic logic [HASH_W-1:0] hash_key(ahs_key_t k);
    logic [HASH_W-1:0] h;
    h = '0;
    for (int unsigned i = 0; i < KEY_W; i++)
      h[i % HASH_W] = h[i % HASH_W] ^ k[i];
    return h;
  endfunction

  // Mask of entry bits lsb..msb
  function automatic ahs_entry_t span(int unsigned lsb,
                                      int unsigned msb);
    ahs_entry_t m;
    for (int unsigned i = 0; i < ENTRY_W; i++)
      m[i] = (i >= lsb) && (i <= msb);
    return m;
  endfunction

  // Group taken from the lower hit when only it claims precedence
  function automatic ahs_entry_t claim(ahs_entry_t lo, ahs_entry_t hi,
                                       int unsigned p, int unsigned lsb,
                                       int unsigned msb);
    if (lo[p] && !hi[p])
      return span(lsb, msb) | span(p, p);
    return '0;
  endfunction

  // Combine two hits: higher wins unless lower holds precedence
  function automatic ahs_entry_t merge_hits(ahs_entry_t lo, logic lo_ok,
                                            ahs_entry_t hi, logic hi_ok);
    ahs_entry_t m;
    if (!hi_ok)
      return lo;
    if (!lo_ok)
      return hi;
    m = claim(lo, hi, P_TAGP, P_TAGV, P_TAGP);
    m = m | claim(lo, hi, P_COPYP, P_COPY, P_COPYP);
    m = m | claim(lo, hi, P_DEIP, P_DEI, P_DEIV);
    m = m | claim(lo, hi, P_PCPP, P_PCP, VIDV_LSB - 2);
    m = m | claim(lo, hi, P_VIDP, P_VID, P_TPID - 1);
    m = m | claim(lo, hi, P_TPIDP, P_TPID, P_DEIP - 1);
    m = m | claim(lo, hi, P_XP, P_XV, XVER_MSB);
    m = m | claim(lo, hi, P_ENCP, P_ENC, P_ENCP);
    return (hi & ~m) | (lo & m);
  endfunction

  // ==========================================================
  // Lookup path
  ahs_key_t key;
  logic [HASH_W-1:0] row;
  ahs_entry_t ent0;
  ahs_entry_t ent1;
  logic hit0;
  logic hit1;
  ahs_entry_t small_res;
  ahs_entry_t c;
  logic chit;

  // Key build, mask, hash, two-bucket compare and selection
  always_comb
  begin
    key = select_key(req.field_sel, req.fields);
    key = key & ahs_key_t'(st.smask);
    row = hash_key(key);
    ent0 = ahs_entry_t'(st.tbl[{1'b0, row}]);
    ent1 = ahs_entry_t'(st.tbl[{1'b1, row}]);
    hit0 = ent0[P_VALID] && (ent0[KEY_LSB +: KEY_W] == key);
    hit1 = ent1[P_VALID] && (ent1[KEY_LSB +: KEY_W] == key);
    small_res = merge_hits(ent0, hit0, ent1, hit1);
    if (!st.sel[0])
    begin
      c = tcam_answer.res;
      chit = tcam_answer.hit;
    end
    else if (st.sel[1])
    begin
      c = large_answer.res;
      chit = large_answer.hit;
    end
    else
    begin
      c = small_res;
      chit = hit0 | hit1;
    end
  end

  // ==========================================================
  // Action decode
  ahs_action_t na;
  logic [7:0] tmask;

  // Originals pass through; result fields act only on a hit
  always_comb
  begin
    na = '0;
    tmask = c[TOSM_LSB +: 8];
    na.valid = req.valid;
    na.tos = req.tos;
    na.dei = req.dei;
    na.pcp = req.pcp;
    na.vid = req.vid;
    na.tpid = req.tpid;
    na.ipv4_sa = req.ipv4_sa;
    na.ipv4_da = req.ipv4_da;
    na.l4_sp = req.l4_sp;
    na.l4_dp = req.l4_dp;
    if (req.valid && chit)
    begin
      na.hit = 1'b1;
      na.to_proc = c[P_TOPROC];
      na.orig_frame = c[P_TOPROC] & c[P_ORIG];
      na.tag_present = c[P_TAGV];
      na.tag = c[TAG_LSB +: 16];
      na.tag_first = c[P_TAGP];
      na.discard = c[P_DROP];
      na.redirect = c[P_REDIR];
      na.redirect_port = c[P_REDIR] ? c[REDIR_LSB +: 4] : 4'h0;
      na.copy = c[P_COPY];
      na.copy_port = c[COPY_LSB +: 4];
      na.copy_first = c[P_COPYP];
      na.skip_learn = c[P_NOLEARN];
      na.stat_bump = c[P_STAT];
      na.stat_idx = c[STAT_LSB +: 6];
      if (c[P_TOS])
        na.tos = (c[TOSV_LSB +: 8] & tmask) | (req.tos & ~tmask);
      if (c[P_DEI])
        na.dei = c[P_DEIV];
      if (c[P_PCP])
        na.pcp = c[PCPV_LSB +: 3];
      if (c[P_VID])
        na.vid = c[VIDV_LSB +: 12];
      if (c[P_TPID])
      begin
        case (c[TPIDC_LSB +: 2])
          TPID_CODE_C: na.tpid = TPID_C;
          TPID_CODE_S: na.tpid = TPID_S;
          TPID_CODE_USER: na.tpid = st.user_tpid;
          default: na.tpid = req.tpid;
        endcase
      end
      if (c[P_IP] && req.is_ipv4)
      begin
        if (c[P_IPSIDE])
          na.ipv4_da = c[IPV_LSB +: 32];
        else
          na.ipv4_sa = c[IPV_LSB +: 32];
      end
      if (c[P_L4])
      begin
        if (c[P_L4SIDE])
          na.l4_dp = c[L4V_LSB +: 16];
        else
          na.l4_sp = c[L4V_LSB +: 16];
      end
      na.xlate_present = c[P_XV];
      na.xlate_ptr = c[XPTR_LSB +: 13];
      na.xlate_first = c[P_XP];
      na.xlate_ver = c[XVER_LSB +: 3];
      na.ptp_flag = c[P_PTP] & c[P_TOPROC];
      na.ptp_ts = (c[P_PTP] & c[P_TOPROC]) ? req.ts : 32'h0;
      na.encap = c[P_ENC];
      na.encap_mc = c[P_ENCMC];
      na.encap_ptr = c[ENCP_LSB +: 5];
      na.encap_first = c[P_ENCP];
    end
  end

  // ==========================================================
  // Register access and counters
  logic [ADDR_W-1:0] toff;
  logic [ADDR_W-1:0] moff;
  logic [ADDR_W-1:0] coff;

  // Writes, read mux, counter updates; increment beats clear
  always_comb
  begin
    next_st = st;
    toff = reg_addr - TBL_BASE;
    moff = reg_addr - SMASK_BASE;
    coff = reg_addr - CNT_BASE;
    next_st.rdata = 32'h0;
    next_st.act = na;
    if (reg_wr)
    begin
      if (reg_addr == SEL_ADDR)
        next_st.sel = reg_wdata[1:0];
      else if (reg_addr == TPID_ADDR)
        next_st.user_tpid = reg_wdata[15:0];
      else if (reg_addr == DROP_ADDR)
        next_st.drops = 32'h0;
      else if (in_win(reg_addr, CNT_BASE, CNT_SPAN))
        next_st.cnt[coff[5:0]] = 32'h0;
      else if (in_win(reg_addr, SMASK_BASE, SMASK_SPAN) && !moff[3])
        next_st.smask[moff[2:0]] = reg_wdata & live_bits(moff[2:0], KEY_W);
      else if (in_win(reg_addr, TBL_BASE, TBL_SPAN))
        next_st.tbl[toff[12:4]][toff[3:0]] =
          reg_wdata & live_bits(toff[3:0], ENTRY_W);
    end
    if (reg_rd)
    begin
      if (reg_addr == SEL_ADDR)
        next_st.rdata = {30'h0, st.sel};
      else if (reg_addr == TPID_ADDR)
        next_st.rdata = {16'h0, st.user_tpid};
      else if (reg_addr == DROP_ADDR)
        next_st.rdata = st.drops;
      else if (in_win(reg_addr, CNT_BASE, CNT_SPAN))
        next_st.rdata = st.cnt[coff[5:0]];
      else if (in_win(reg_addr, SMASK_BASE, SMASK_SPAN) && !moff[3])
        next_st.rdata = st.smask[moff[2:0]];
      else if (in_win(reg_addr, TBL_BASE, TBL_SPAN))
        next_st.rdata = st.tbl[toff[12:4]][toff[3:0]];
    end
    if (na.discard)
      next_st.drops = next_st.drops + 32'h1;
    if (na.stat_bump)
      next_st.cnt[na.stat_idx] = next_st.cnt[na.stat_idx] + 32'h1;
    if (!rst_n)
    begin
      next_st = '0;
      next_st.sel = SEL_RESET;
      next_st.smask = SMASK_RESET;
      next_st.user_tpid = USER_TPID_RESET;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  assign reg_rdata = st.rdata;
  assign act = st.act;

endmodule // ahs_small_lookup

`default_nettype wire

// ---- core/ahs_pkg.sv ----
// Package: constants and carriers for the small-table classification lookup
package ahs_pkg;

  // ==========================================================
  // Register bus and map (word addresses)
  localparam int unsigned ADDR_W = 21;
  localparam logic [20:0] SEL_ADDR = 21'h111bc9;
  localparam logic [20:0] TBL_BASE = 21'h04d824;
  localparam logic [20:0] TBL_SPAN = 21'h002000;
  localparam logic [20:0] SMASK_BASE = 21'h1127bb;
  localparam logic [20:0] SMASK_SPAN = 21'h000010;
  localparam logic [20:0] TPID_ADDR = 21'h1f0000;
  localparam logic [20:0] DROP_ADDR = 21'h1f0001;
  localparam logic [20:0] CNT_BASE = 21'h1f0040;
  localparam logic [20:0] CNT_SPAN = 21'h000040;

  // ==========================================================
  // Table geometry and key
  localparam int unsigned ENTRIES = 512;
  localparam int unsigned WORDS = 16;
  localparam int unsigned ENTRY_W = 453;
  localparam int unsigned KEY_W = 235;
  localparam int unsigned HASH_W = 8;
  localparam int unsigned NFIELDS = 39;
  localparam int unsigned FIELD_W = 32;
  localparam int unsigned KEY_FIELDS = 7;
  localparam int unsigned MASK_WORDS = 8;
  localparam int unsigned NCNT = 64;

  // ==========================================================
  // Reset values and fixed codes
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [15:0] USER_TPID_RESET = 16'h0000;
  localparam logic [255:0] SMASK_RESET = {21'h0, {235{1'b1}}};
  localparam logic [15:0] TPID_C = 16'h8100;
  localparam logic [15:0] TPID_S = 16'h88a8;
  localparam logic [1:0] TPID_CODE_C = 2'h0;
  localparam logic [1:0] TPID_CODE_S = 2'h1;
  localparam logic [1:0] TPID_CODE_USER = 2'h2;

  // ==========================================================
  // Entry field positions
  localparam int unsigned P_VALID = 0;
  localparam int unsigned KEY_LSB = 1;
  localparam int unsigned P_TOPROC = 236;
  localparam int unsigned P_ORIG = 237;
  localparam int unsigned P_TAGV = 238;
  localparam int unsigned TAG_LSB = 239;
  localparam int unsigned P_TAGP = 255;
  localparam int unsigned P_DROP = 256;
  localparam int unsigned P_REDIR = 257;
  localparam int unsigned REDIR_LSB = 258;
  localparam int unsigned P_COPY = 262;
  localparam int unsigned COPY_LSB = 263;
  localparam int unsigned P_COPYP = 267;
  localparam int unsigned P_NOLEARN = 268;
  localparam int unsigned P_STAT = 269;
  localparam int unsigned STAT_LSB = 270;
  localparam int unsigned P_TOS = 276;
  localparam int unsigned TOSV_LSB = 277;
  localparam int unsigned TOSM_LSB = 285;
  localparam int unsigned P_DEI = 293;
  localparam int unsigned P_DEIV = 294;
  localparam int unsigned P_PCP = 295;
  localparam int unsigned PCPV_LSB = 296;
  localparam int unsigned P_VID = 299;
  localparam int unsigned VIDV_LSB = 300;
  localparam int unsigned P_TPID = 312;
  localparam int unsigned TPIDC_LSB = 313;
  localparam int unsigned P_DEIP = 315;
  localparam int unsigned P_PCPP = 316;
  localparam int unsigned P_VIDP = 317;
  localparam int unsigned P_TPIDP = 318;
  localparam int unsigned P_IP = 319;
  localparam int unsigned P_IPSIDE = 320;
  localparam int unsigned IPV_LSB = 321;
  localparam int unsigned P_L4 = 353;
  localparam int unsigned P_L4SIDE = 354;
  localparam int unsigned L4V_LSB = 355;
  localparam int unsigned P_XV = 371;
  localparam int unsigned XPTR_LSB = 372;
  localparam int unsigned P_XP = 385;
  localparam int unsigned XVER_LSB = 386;
  localparam int unsigned XVER_MSB = 388;
  localparam int unsigned P_PTP = 389;
  localparam int unsigned P_ENC = 390;
  localparam int unsigned P_ENCMC = 391;
  localparam int unsigned ENCP_LSB = 392;
  localparam int unsigned P_ENCP = 397;

  // ==========================================================
  // Carriers
  typedef logic [ENTRY_W-1:0] ahs_entry_t;
  typedef logic [KEY_W-1:0] ahs_key_t;

  typedef struct packed {
    logic valid;
    logic [NFIELDS-1:0] field_sel;
    logic [NFIELDS-1:0][FIELD_W-1:0] fields;
    logic is_ipv4;
    logic [7:0] tos;
    logic dei;
    logic [2:0] pcp;
    logic [11:0] vid;
    logic [15:0] tpid;
    logic [31:0] ipv4_sa;
    logic [31:0] ipv4_da;
    logic [15:0] l4_sp;
    logic [15:0] l4_dp;
    logic [31:0] ts;
  } ahs_req_t;

  typedef struct packed {
    logic hit;
    ahs_entry_t res;
  } ahs_answer_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic to_proc;
    logic orig_frame;
    logic tag_present;
    logic tag_first;
    logic [15:0] tag;
    logic discard;
    logic redirect;
    logic [3:0] redirect_port;
    logic copy;
    logic copy_first;
    logic [3:0] copy_port;
    logic skip_learn;
    logic stat_bump;
    logic [5:0] stat_idx;
    logic [7:0] tos;
    logic dei;
    logic [2:0] pcp;
    logic [11:0] vid;
    logic [15:0] tpid;
    logic [31:0] ipv4_sa;
    logic [31:0] ipv4_da;
    logic [15:0] l4_sp;
    logic [15:0] l4_dp;
    logic xlate_present;
    logic xlate_first;
    logic [12:0] xlate_ptr;
    logic [2:0] xlate_ver;
    logic ptp_flag;
    logic [31:0] ptp_ts;
    logic encap;
    logic encap_mc;
    logic encap_first;
    logic [4:0] encap_ptr;
  } ahs_action_t;

endpackage

// ---- dv/ahs_small_lookup_chk.sv ----
// Port checker for the small-table classification lookup
`timescale 1ns/10ps
`default_nettype none
module ahs_small_lookup_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire ahs_pkg::ahs_req_t req,
  input wire ahs_pkg::ahs_action_t act
);
  import ahs_pkg::*;
  // ==========================================================
  // Clocking
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Properties
  // Decision pulse follows the request by exactly one cycle
  property p_valid;
    $past(rst_n) |-> act.valid == $past(req.valid);
  endproperty
  a_valid: assert property (p_valid)
    else $error("action valid out of step with request");
  // A miss raises none of the eight main action flags
  property p_nohit;
    !act.hit |-> !(act.to_proc | act.discard | act.redirect | act.copy
      | act.skip_learn | act.stat_bump | act.encap | act.xlate_present);
  endproperty
  a_nohit: assert property (p_nohit)
    else $error("action flag raised without a hit");
  // Discard only on a hit of a real packet
  property p_drop;
    act.discard |-> act.hit && act.valid;
  endproperty
  a_drop: assert property (p_drop)
    else $error("discard without a hit");
  // Redirect needs a hit, port reads zero otherwise
  property p_redir;
    1'b1 |-> (act.redirect ? act.hit : act.redirect_port == 4'h0);
  endproperty
  a_redir: assert property (p_redir)
    else $error("redirect port inconsistent");
  // Original frame delivery only toward the processor
  property p_orig;
    act.orig_frame |-> act.to_proc;
  endproperty
  a_orig: assert property (p_orig)
    else $error("original frame without processor forwarding");
  // Timestamp copied from the request that caused it
  property p_ptp;
    $past(rst_n) && act.ptp_flag
      |-> act.to_proc && act.ptp_ts == $past(req.ts);
  endproperty
  a_ptp: assert property (p_ptp)
    else $error("timestamp flag or value wrong");
  // Source address changes only on an IPv4 hit
  property p_ipv4;
    $past(rst_n) && act.ipv4_sa != $past(req.ipv4_sa)
      |-> $past(req.is_ipv4) && act.hit;
  endproperty
  a_ipv4: assert property (p_ipv4)
    else $error("address rewritten on a non-IPv4 packet");
  // Misses pass the original TOS and TPID values through
  property p_tos;
    $past(rst_n) && !act.hit
      |-> act.tos == $past(req.tos) && act.tpid == $past(req.tpid);
  endproperty
  a_tos: assert property (p_tos)
    else $error("header value changed on a miss");
  // Main scenarios
  c_drop: cover property (act.hit && act.discard);
  c_proc: cover property (act.to_proc && act.ptp_flag);
  c_miss: cover property (act.valid && !act.hit);
endmodule // ahs_small_lookup_chk

bind ahs_small_lookup ahs_small_lookup_chk u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .req(req),
  .act(act)
);
`default_nettype wire

// ---- dv/ahs_far_end.sv ----
// Far-side model: TCAM and large table answers
`timescale 1ns/10ps
`default_nettype none
module ahs_far_end (
  input wire logic answer_on,
  output ahs_pkg::ahs_answer_t tcam_answer,
  output ahs_pkg::ahs_answer_t large_answer
);
  import ahs_pkg::*;
  // TCAM hit redirects to port 6, large hit goes to processor
  always_comb
  begin
    tcam_answer = '0;
    large_answer = '0;
    tcam_answer.hit = answer_on;
    tcam_answer.res[P_REDIR] = 1'b1;
    tcam_answer.res[REDIR_LSB +: 4] = 4'h6;
    large_answer.hit = answer_on;
    large_answer.res[P_TOPROC] = 1'b1;
  end
endmodule // ahs_far_end
`default_nettype wire

// ---- dv/tb.sv ----
// Testbench for the small-table classification lookup
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ahs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic far_on = 1'b0;
  logic [31:0] reg_rdata;
  ahs_req_t req = '0;
  ahs_answer_t tcam_answer;
  ahs_answer_t large_answer;
  ahs_action_t act;
  int err_count = 0;
  int check_count = 0;
  logic [15:0] tp [3] = '{TPID_C, TPID_S, 16'h9100};
  // ==========================================================
  // Clock, partner and device
  always #2 clk = ~clk;
  ahs_far_end u_far (
    .answer_on(far_on),
    .tcam_answer(tcam_answer),
    .large_answer(large_answer)
  );
  ahs_small_lookup uut (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .req(req),
    .tcam_answer(tcam_answer),
    .large_answer(large_answer),
    .act(act)
  );
  // ==========================================================
  // Tasks
  // Verdict and end of run
  task automatic close_out;
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Value comparison
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [20:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [20:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  // Table word write: row, word, data
  task automatic ent(input int row, input int w, input logic [31:0] d);
    wr(TBL_BASE + 21'(16 * row + w), d);
  endtask
  // One IPv4 packet keyed on field 3, decision settled on return
  task automatic look(input logic [31:0] v);
    ahs_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.field_sel = 39'h8;
    r.fields[3] = v;
    r.is_ipv4 = 1'b1;
    r.tos = 8'h5a;
    r.tpid = 16'h0800;
    r.ipv4_sa = 32'hc0a80001;
    r.ts = 32'h12345678;
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
  endtask
  // ==========================================================
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(SEL_ADDR, 32'h0);
    rd(SMASK_BASE + 21'h7, 32'h000007ff);
    rd(SMASK_BASE + 21'h8, 32'h0);
    rd(21'h000123, 32'h0);
    wr(SEL_ADDR, 32'h1);
    rd(SEL_ADDR, 32'h1);
    wr(TPID_ADDR, 32'h9100);
    // Key 5 hashes to row 5; bucket 1 copy at row 261 starts invalid
    ent(5, 0, 32'hb);
    ent(5, 8, 32'he027);
    ent(261, 0, 32'ha);
    ent(261, 7, 32'h3000);
    ent(261, 12, 32'h20);
    ent(261, 10, 32'h14000002);
    look(32'h5);
    chk("hit", 32'h1, 32'(act.hit));
    chk("to_proc", 32'h0, 32'(act.to_proc));
    chk("discard", 32'h1, 32'(act.discard));
    chk("redirect_port", 32'h9, 32'(act.redirect_port));
    chk("stat_idx", 32'h3, 32'(act.stat_idx));
    rd(DROP_ADDR, 32'h1);
    rd(CNT_BASE + 21'h3, 32'h1);
    // Both buckets valid: bucket 1 wins, TPID codes 0 to 2
    ent(261, 0, 32'hb);
    for (int c = 0; c < 3; c++)
    begin
      ent(261, 9, 32'h81000000 | (32'(c) << 25));
      look(32'h5);
      chk("tpid", 32'(tp[c]), 32'(act.tpid));
      chk("to_proc", 32'h1, 32'(act.to_proc));
      chk("discard", 32'h0, 32'(act.discard));
    end
    chk("orig_frame", 32'h1, 32'(act.orig_frame));
    chk("ptp_ts", 32'h12345678, act.ptp_ts);
    chk("ipv4_sa", 32'h0a000001, act.ipv4_sa);
    rd(DROP_ADDR, 32'h1);
    look(32'h6);
    chk("hit", 32'h0, 32'(act.hit));
    chk("tos", 32'h5a, 32'(act.tos));
    // Lower bucket keeps its copy group through its precedence bit
    ent(5, 8, 32'hfae7);
    ent(261, 8, 32'h140);
    ent(261, 11, 32'h91a6);
    ent(261, 12, 32'h13e0);
    look(32'h5);
    chk("copy", 32'h1, 32'(act.copy));
    chk("copy_port", 32'h5, 32'(act.copy_port));
    chk("copy_first", 32'h1, 32'(act.copy_first));
    chk("skip_learn", 32'h0, 32'(act.skip_learn));
    chk("discard", 32'h0, 32'(act.discard));
    chk("l4_dp", 32'h1234, 32'(act.l4_dp));
    chk("encap", 32'h1, 32'(act.encap));
    chk("encap_mc", 32'h1, 32'(act.encap_mc));
    chk("encap_ptr", 32'h13, 32'(act.encap_ptr));
    // Masked key falls to an empty row
    wr(SMASK_BASE, 32'hfffffffa);
    look(32'h5);
    chk("hit", 32'h0, 32'(act.hit));
    wr(SMASK_BASE, 32'hffffffff);
    // TCAM then large answers selected
    far_on <= 1'b1;
    wr(SEL_ADDR, 32'h0);
    look(32'h5);
    chk("redirect_port", 32'h6, 32'(act.redirect_port));
    wr(SEL_ADDR, 32'h3);
    look(32'h5);
    chk("to_proc", 32'h1, 32'(act.to_proc));
    chk("orig_frame", 32'h0, 32'(act.orig_frame));
    close_out();
  end
endmodule // tb
`default_nettype wire
